// File: hw/fsl_pkg.sv
// package: constants and carrier types for the fault status latch block
//
// Notes on behaviour
// - The output-off flag is set at power-on and whenever a fault turns the regulated output off.
// - The output-off flag going to one never drives the fault alert output.
// - The output-off flag clears at the stop that ends a write sequence if the output is then enabled.
// - Overcurrent lasting past 48 ms turns the output off and sets the overcurrent and output-off flags.
// - The ninth clock rise of every read byte updates the status and clears the overcurrent flag unless overcurrent is live with the timer off.
// - With the overcurrent timer off, the overcurrent flag follows the live overcurrent level.
// - A thermal shutdown caused by long overcurrent turns the output off and sets the thermal flag.
// - The power-bad flag sets below 85% while enabled and clears on its own within 90%.
// - Overtemperature turns the output off and sets the thermal flag and the output-off flag.
// - The ninth clock rise of a read byte reloads the thermal flag from the live overtemperature level.
// - Supply undervoltage turns the output off, sets both flags, and the output stays off until rewritten.
// - The ninth clock rise of a read byte reloads the supply-low flag from the live undervoltage level.
// - Read bytes alternate primary, secondary, primary, and each new read starts at the primary.
// - Writing the enable bit 5 as one turns the output on and as zero turns it off.
`default_nettype none

package fsl_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int OCP_TIME_MS = 48;
	localparam int OCP_CYCLES = OCP_TIME_MS * (CLK_HZ / 1000);
	localparam int OCP_CNT_W = 23;

	// ****************************************
	// serial bus
	// ****************************************
	localparam logic [6:0] DEV_ADDR_DEF = 7'h08; // arbitrary value
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ****************************************
	// control byte layout
	// ****************************************
	localparam int CTRL_SEL_HI = 7;
	localparam int CTRL_SEL_LO = 6;
	localparam logic [1:0] CTRL0_SEL = 2'h0;
	localparam logic [1:0] CTRL1_SEL = 2'h2;
	localparam int VSEL_HI = 3;
	localparam int ODT_BIT = 4;
	localparam int ENB_BIT = 5;
	localparam int TMODE_BIT = 0;
	localparam int TGATE_BIT = 1;
	localparam logic [5:0] CTRL0_RST = 6'h00;
	localparam logic [1:0] CTRL1_RST = 2'h0;

	// ****************************************
	// status register layout
	// ****************************************
	localparam int DIS_BIT = 0;
	localparam int OCP_BIT = 2;
	localparam int PNG_BIT = 4;
	localparam int TSD_BIT = 6;
	localparam int VUV_BIT = 7;
	localparam logic [7:0] STATUS2_VAL = 8'h00;
	localparam logic DIS_RST = 1'b1;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic over_current;
		logic over_temp;
		logic supply_low;
		logic below_85;
		logic within_90;
	} fsl_fault_t;

	typedef struct packed {
		logic [3:0] voltage_select;
		logic timer_enable;
		logic tone_internal;
		logic tone_gate;
	} fsl_ctrl_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_WRITE = 3'b011,
		ST_WRITE_ACK = 3'b100,
		ST_READ = 3'b101,
		ST_READ_ACK = 3'b110
	} fsl_state_t;

endpackage : fsl_pkg

`default_nettype wire

// File: hw/fsl_sync.sv
// module: two-stage synchroniser for asynchronous levels
`default_nettype none

module fsl_sync
	import fsl_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// first stage feeds only the second
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule : fsl_sync

`default_nettype wire

// File: hw/fsl_ocp_timer.sv
// module: overcurrent persistence timer
`default_nettype none

module fsl_ocp_timer
	import fsl_pkg::*;
#(
	parameter int CNT_W = OCP_CNT_W,
	parameter int TRIP_CYCLES = OCP_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// condition
	input wire logic run,
	// result
	output logic trip
);

	localparam logic [CNT_W-1:0] LAST = CNT_W'(TRIP_CYCLES - 1);

	logic [CNT_W-1:0] count_ff;
	logic trip_ff;
	wire at_last = (count_ff == LAST);

	// count restarts whenever the condition drops, so short bursts never add up
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count_ff <= '0;
			trip_ff <= 1'b0;
		end else begin
			count_ff <= (run && !at_last) ? count_ff + 1'b1 : '0;
			trip_ff <= run && at_last;
		end
	end

	assign trip = trip_ff;

endmodule : fsl_ocp_timer

`default_nettype wire

// File: hw/fsl_top.sv
// module: serial-bus fault status latch with control registers
`default_nettype none

module fsl_top
	import fsl_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
	parameter int OCP_TRIP_CYCLES = OCP_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// serial bus pins (open drain data)
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// analog fault detectors, asynchronous
	input wire fsl_fault_t fault_in,
	// regulator controls
	output logic regulated_output,
	output var fsl_ctrl_t ctrl_out,
	// fault alert, overcurrent, thermal and supply-low flags only
	output logic fault_alert
);

	// ****************************************
	// input synchronisation
	// ****************************************
	logic [1:0] bus_s;
	fsl_fault_t flt;

	fsl_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in({scl_in, sda_in}),
		.sync_out(bus_s)
	);

	fsl_sync #(.WIDTH($bits(fsl_fault_t)), .RST_VAL('0)) u_flt_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in(fault_in),
		.sync_out(flt)
	);

	// ****************************************
	// bus edge detection
	// ****************************************
	logic scl_q_ff;
	logic sda_q_ff;
	wire scl_s = bus_s[1];
	wire sda_s = bus_s[0];
	wire scl_rise = scl_s && !scl_q_ff;
	wire scl_fall = !scl_s && scl_q_ff;
	wire bus_start = scl_s && scl_q_ff && sda_q_ff && !sda_s;
	wire bus_stop = scl_s && scl_q_ff && !sda_q_ff && sda_s;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= scl_s;
			sda_q_ff <= sda_s;
		end
	end

	// ****************************************
	// serial slave state
	// ****************************************
	fsl_state_t state_ff;
	fsl_state_t nxt_state;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic rd_sel_ff;
	logic nxt_rd_sel;
	logic wrote_ff;
	logic nxt_wrote;
	logic sda_oe_ff;
	logic [7:0] status1;

	wire byte_in = (cnt_ff == BITS_PER_BYTE);
	wire addr_hit = (shift_ff[7:1] == DEV_ADDR);
	wire [7:0] rd_byte = rd_sel_ff ? STATUS2_VAL : status1;

	// ninth clock rise of a read byte and commit of a written byte
	wire read_ninth = (state_ff == ST_READ_ACK) && scl_rise;
	wire write_ninth = (state_ff == ST_WRITE_ACK) && scl_rise;
	// write sequence ends at the stop condition
	wire write_done = bus_stop && wrote_ff;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_rd_sel = rd_sel_ff;
		nxt_wrote = wrote_ff;
		if (bus_start) begin
			// a new read always begins with the primary register
			nxt_state = ST_ADDR;
			nxt_cnt = 4'h0;
			nxt_rd_sel = 1'b0;
			nxt_wrote = 1'b0;
		end else if (bus_stop) begin
			nxt_state = ST_IDLE;
			nxt_wrote = 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					nxt_state = ST_IDLE;
				end
				ST_ADDR, ST_WRITE: begin
					if (scl_rise) begin
						nxt_shift = {shift_ff[6:0], sda_s};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && byte_in) begin
						if (state_ff == ST_WRITE) begin
							nxt_state = ST_WRITE_ACK;
						end else if (addr_hit) begin
							nxt_state = ST_ADDR_ACK;
						end else begin
							nxt_state = ST_IDLE;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						nxt_cnt = 4'h0;
						if (shift_ff[0]) begin
							nxt_state = ST_READ;
							nxt_shift = rd_byte;
						end else begin
							nxt_state = ST_WRITE;
						end
					end
				end
				ST_WRITE_ACK: begin
					if (scl_rise) begin
						nxt_wrote = 1'b1;
					end else if (scl_fall) begin
						nxt_state = ST_WRITE;
						nxt_cnt = 4'h0;
					end
				end
				ST_READ: begin
					if (scl_rise) begin
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall) begin
						if (byte_in) begin
							nxt_state = ST_READ_ACK;
						end else begin
							nxt_shift = {shift_ff[6:0], 1'b0};
						end
					end
				end
				ST_READ_ACK: begin
					if (scl_rise) begin
						// master ack keeps the read going, nack ends it
						nxt_cnt = sda_s ? 4'hf : 4'h0;
					end else if (scl_fall) begin
						if (cnt_ff == 4'h0) begin
							nxt_state = ST_READ;
							nxt_rd_sel = !rd_sel_ff;
							nxt_shift = rd_sel_ff ? status1 : STATUS2_VAL;
						end else begin
							nxt_state = ST_IDLE;
						end
					end
				end
				default: begin
					nxt_state = ST_IDLE;
				end
			endcase
		end
	end

	// open drain: only ever pull low
	wire nxt_sda_oe = (state_ff == ST_ADDR_ACK) || (state_ff == ST_WRITE_ACK) ||
		((state_ff == ST_READ) && !shift_ff[7]);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			rd_sel_ff <= 1'b0;
			wrote_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			rd_sel_ff <= nxt_rd_sel;
			wrote_ff <= nxt_wrote;
			sda_oe_ff <= nxt_sda_oe;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_ff;

	// ****************************************
	// control registers
	// ****************************************
	logic [5:0] ctrl0_ff;
	logic [1:0] ctrl1_ff;
	logic out_on_ff;
	logic nxt_out_on;

	wire [1:0] wr_sel = shift_ff[CTRL_SEL_HI:CTRL_SEL_LO];
	wire wr_ctrl0 = write_ninth && (wr_sel == CTRL0_SEL);
	wire wr_ctrl1 = write_ninth && (wr_sel == CTRL1_SEL);
	wire timer_on = ctrl0_ff[ODT_BIT];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl0_ff <= CTRL0_RST;
			ctrl1_ff <= CTRL1_RST;
		end else begin
			if (wr_ctrl0) begin
				ctrl0_ff <= shift_ff[5:0];
			end
			if (wr_ctrl1) begin
				ctrl1_ff <= shift_ff[1:0];
			end
		end
	end

	assign ctrl_out.voltage_select = ctrl0_ff[VSEL_HI:0];
	assign ctrl_out.timer_enable = ctrl0_ff[ODT_BIT];
	assign ctrl_out.tone_internal = ctrl1_ff[TMODE_BIT];
	assign ctrl_out.tone_gate = ctrl1_ff[TGATE_BIT];

	// ****************************************
	// fault detection and output switch
	// ****************************************
	logic ocp_trip;

	fsl_ocp_timer #(.CNT_W(OCP_CNT_W), .TRIP_CYCLES(OCP_TRIP_CYCLES)) u_ocp_timer (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.run(flt.over_current && timer_on && out_on_ff),
		.trip(ocp_trip)
	);

	// thermal trip covers overtemperature from any cause, long overcurrent included
	wire temp_trip = flt.over_temp;
	wire low_trip = flt.supply_low;
	wire any_trip = ocp_trip || temp_trip || low_trip;

	// a trip outranks a same-cycle enable write; undervoltage needs a fresh write
	always_comb begin
		nxt_out_on = out_on_ff;
		if (wr_ctrl0) begin
			nxt_out_on = shift_ff[ENB_BIT];
		end
		if (any_trip) begin
			nxt_out_on = 1'b0;
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	logic dis_ff;
	logic ocp_ff;
	logic png_ff;
	logic tsd_ff;
	logic vuv_ff;

	wire dis_set = any_trip || !nxt_out_on;
	wire ocp_set = ocp_trip || (!timer_on && flt.over_current);
	wire ocp_clr = read_ninth || (!timer_on && !flt.over_current);
	wire png_set = out_on_ff && flt.below_85;
	wire png_clr = !out_on_ff || flt.within_90;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_on_ff <= 1'b0;
			dis_ff <= DIS_RST;
			ocp_ff <= 1'b0;
			png_ff <= 1'b0;
			tsd_ff <= 1'b0;
			vuv_ff <= 1'b0;
		end else begin
			out_on_ff <= nxt_out_on;
			// set wins over clear on every flag
			if (dis_set) begin
				dis_ff <= 1'b1;
			end else if (write_done) begin
				dis_ff <= 1'b0;
			end
			if (ocp_set) begin
				ocp_ff <= 1'b1;
			end else if (ocp_clr) begin
				ocp_ff <= 1'b0;
			end
			if (png_set) begin
				png_ff <= 1'b1;
			end else if (png_clr) begin
				png_ff <= 1'b0;
			end
			if (temp_trip) begin
				tsd_ff <= 1'b1;
			end else if (read_ninth) begin
				tsd_ff <= 1'b0;
			end
			if (low_trip) begin
				vuv_ff <= 1'b1;
			end else if (read_ninth) begin
				vuv_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		status1 = 8'h00;
		status1[DIS_BIT] = dis_ff;
		status1[OCP_BIT] = ocp_ff;
		status1[PNG_BIT] = png_ff;
		status1[TSD_BIT] = tsd_ff;
		status1[VUV_BIT] = vuv_ff;
	end

	assign regulated_output = out_on_ff;
	// output-off flag left out, since the host may switch off on purpose
	assign fault_alert = ocp_ff || tsd_ff || vuv_ff;

endmodule : fsl_top

`default_nettype wire

// File: dv/fsl_chk.sv
// checker: port-level timing of fault flags and output switch
`default_nettype none
module fsl_chk
	import fsl_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
	parameter int OCP_TRIP_CYCLES = OCP_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// faults and controls
	input wire fsl_fault_t fault_in,
	input wire logic regulated_output,
	input wire fsl_ctrl_t ctrl_out,
	input wire logic fault_alert
);
	timeunit 1ns;
	timeprecision 100ps;
	logic cause;
	int oc_run_ff;
	int nxt_oc_run;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	assign cause = fault_in.over_current | fault_in.over_temp | fault_in.supply_low;
	// raw pin leads the design by its sync stages, hence the slack
	assign nxt_oc_run = (ctrl_out.timer_enable && regulated_output && fault_in.over_current) ? oc_run_ff + 1 : 0;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			oc_run_ff <= 0;
		end else begin
			oc_run_ff <= nxt_oc_run;
		end
	end
	property p_reset_off;
		$rose(reset_n) |-> !regulated_output && !fault_alert;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("output or alert up after reset");
	property p_alert_cause;
		$rose(fault_alert) |-> $past(cause, 2) || $past(cause, 3) || $past(cause, 4);
	endproperty
	a_alert_cause: assert property (p_alert_cause) else $error("alert without fault");
	property p_uv_off;
		fault_in.supply_low [*6] |-> !regulated_output && fault_alert;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("supply low kept output on");
	property p_temp_off;
		fault_in.over_temp [*6] |-> !regulated_output;
	endproperty
	a_temp_off: assert property (p_temp_off) else $error("overtemperature kept output on");
	property p_ocp_follow;
		(!ctrl_out.timer_enable && fault_in.over_current) [*6] |-> fault_alert;
	endproperty
	a_ocp_follow: assert property (p_ocp_follow) else $error("overcurrent not flagged");
	property p_ocp_trip;
		oc_run_ff <= OCP_TRIP_CYCLES + 8;
	endproperty
	a_ocp_trip: assert property (p_ocp_trip) else $error("overcurrent timer late");
	property p_en_by_bus;
		$rose(regulated_output) |-> $past(scl_in, 2);
	endproperty
	a_en_by_bus: assert property (p_en_by_bus) else $error("output on outside bus clock");
	property p_clear_on_read;
		$fell(fault_alert) && ctrl_out.timer_enable |-> $past(scl_in, 2);
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("flag cleared without read");
	property p_sda_stand;
		scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3) |-> $stable(sda_oe);
	endproperty
	a_sda_stand: assert property (p_sda_stand) else $error("data moved while clock high");
	c_trip: cover property ($fell(regulated_output));
	c_ack: cover property ($rose(sda_oe));
	c_alert: cover property ($rose(fault_alert));
endmodule : fsl_chk

bind fsl_top fsl_chk #(.DEV_ADDR(DEV_ADDR), .OCP_TRIP_CYCLES(OCP_TRIP_CYCLES)) u_chk (.ref_clk(ref_clk),
	.reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.fault_in(fault_in), .regulated_output(regulated_output), .ctrl_out(ctrl_out), .fault_alert(fault_alert));
`default_nettype wire

// File: dv/fsl_host.sv
// partner: serial bus master reading status and writing control
`default_nettype none
module fsl_host
	import fsl_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
	// clock
	input wire logic ref_clk,
	// bus pins, data is open drain
	input wire logic sda,
	output var logic scl,
	output var logic sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] q [4];
	logic ackd;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	// phases of 10 cycles, well above the design's sync lag
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		tick(5);
		scl = 1'b1;
		tick(10);
		r = sda;
		scl = 1'b0;
		tick(5);
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic a);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], b);
			r[i] = b;
		end
		bit_io(ack_in, a);
	endtask : byte_io
	task automatic start;
		sda_low = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(5);
		sda_low = 1'b1;
		tick(5);
		scl = 1'b0;
		tick(5);
	endtask : start
	task automatic stop;
		sda_low = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(5);
		sda_low = 1'b0;
		tick(10);
	endtask : stop
	task automatic wr(input logic [6:0] ad, input logic [7:0] d);
		logic [7:0] r;
		logic a;
		start;
		byte_io({ad, 1'b0}, 1'b1, r, a);
		ackd = !a;
		if (!a) begin
			byte_io(d, 1'b1, r, a);
		end
		stop;
	endtask : wr
	// every read opens with a fresh start, last byte refused
	task automatic rd(input int n);
		logic [7:0] r;
		logic a;
		start;
		byte_io({DEV_ADDR, 1'b1}, 1'b1, r, a);
		for (int k = 0; k < n; k++) begin
			byte_io(8'hff, k == n - 1, r, a);
			q[k] = r;
		end
		stop;
	endtask : rd
endmodule : fsl_host
`default_nettype wire

// File: dv/test_fault_status_latch_register.sv
// testbench: fault status latch through its serial bus
`default_nettype none
module test_fault_status_latch_register
	import fsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TRIP = 20;
	logic ref_clk, reset_n, scl, sda_low, sda_w, sda_out, sda_oe, regulated_output, fault_alert;
	fsl_fault_t fault_in;
	fsl_ctrl_t ctrl_out;
	int failures = 0;
	int checks_done = 0;
	// pulled-up data wire
	assign sda_w = !(sda_low | sda_oe);
	fsl_top #(.OCP_TRIP_CYCLES(TRIP)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .fault_in(fault_in), .regulated_output(regulated_output),
		.ctrl_out(ctrl_out), .fault_alert(fault_alert));
	fsl_host u_host (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] e);
		u_host.rd(1);
		chk("primary", e, u_host.q[0]);
	endtask : rd_chk
	task automatic t_reset;
		u_host.rd(3);
		chk("primary", 8'h01, u_host.q[0]);
		chk("secondary", 8'h00, u_host.q[1]);
		chk("third", 8'h01, u_host.q[2]);
		rd_chk(8'h01);
		chk("alert", 8'h00, 8'(fault_alert));
		chk("controls", 8'h00, 8'(ctrl_out));
	endtask : t_reset
	task automatic t_enable;
		u_host.wr(DEV_ADDR_DEF ^ 7'h01, 8'h30);
		chk("foreign ack", 8'h00, 8'(u_host.ackd));
		chk("output", 8'h00, 8'(regulated_output));
		u_host.wr(DEV_ADDR_DEF, 8'h30);
		chk("output", 8'h01, 8'(regulated_output));
		rd_chk(8'h00);
		u_host.wr(DEV_ADDR_DEF, 8'h10);
		chk("output", 8'h00, 8'(regulated_output));
		rd_chk(8'h01);
		chk("alert", 8'h00, 8'(fault_alert));
	endtask : t_enable
	// latched trip: held over two reads, cleared by the read after it ends
	task automatic t_latched(input int which, input logic [7:0] flag);
		u_host.wr(DEV_ADDR_DEF, 8'h30);
		fault_in[which] = 1'b1;
		u_host.tick(20);
		chk("output", 8'h00, 8'(regulated_output));
		chk("alert", 8'h01, 8'(fault_alert));
		rd_chk(flag | 8'h01);
		rd_chk(flag | 8'h01);
		fault_in[which] = 1'b0;
		u_host.tick(10);
		rd_chk(flag | 8'h01);
		rd_chk(8'h01);
		chk("output", 8'h00, 8'(regulated_output));
		chk("alert", 8'h00, 8'(fault_alert));
	endtask : t_latched
	task automatic t_ocp_timer;
		u_host.wr(DEV_ADDR_DEF, 8'h30);
		fault_in.over_current = 1'b1;
		u_host.tick(TRIP / 2);
		chk("output", 8'h01, 8'(regulated_output));
		u_host.tick(TRIP + 10);
		chk("output", 8'h00, 8'(regulated_output));
		rd_chk(8'h05);
		rd_chk(8'h01);
		fault_in.over_current = 1'b0;
		u_host.wr(DEV_ADDR_DEF, 8'h30);
		chk("output", 8'h01, 8'(regulated_output));
	endtask : t_ocp_timer
	task automatic t_ocp_limit;
		u_host.wr(DEV_ADDR_DEF, 8'h20);
		fault_in.over_current = 1'b1;
		u_host.tick(TRIP * 4);
		chk("output", 8'h01, 8'(regulated_output));
		rd_chk(8'h04);
		fault_in.over_current = 1'b0;
		u_host.tick(10);
		chk("alert", 8'h00, 8'(fault_alert));
		rd_chk(8'h00);
	endtask : t_ocp_limit
	task automatic t_power_bad;
		fault_in.below_85 = 1'b1;
		u_host.tick(10);
		rd_chk(8'h10);
		fault_in.below_85 = 1'b0;
		fault_in.within_90 = 1'b1;
		u_host.tick(10);
		rd_chk(8'h00);
	endtask : t_power_bad
	// every control field but the timer enable set; selects 01 and 11 must leave both registers alone
	task automatic t_controls;
		u_host.wr(DEV_ADDR_DEF, 8'h2b);
		chk("controls", 8'h58, 8'(ctrl_out));
		chk("output", 8'h01, 8'(regulated_output));
		u_host.wr(DEV_ADDR_DEF, 8'h83);
		chk("controls", 8'h5b, 8'(ctrl_out));
		u_host.wr(DEV_ADDR_DEF, 8'h40);
		u_host.wr(DEV_ADDR_DEF, 8'hc0);
		chk("controls", 8'h5b, 8'(ctrl_out));
		chk("output", 8'h01, 8'(regulated_output));
		rd_chk(8'h00);
		chk("data value", 8'h00, 8'(sda_out));
	endtask : t_controls
	initial begin
		fault_in = '0;
		reset_n = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		u_host.tick(6);
		t_reset;
		t_enable;
		t_latched(3, 8'h40);
		t_latched(2, 8'h80);
		t_ocp_timer;
		t_ocp_limit;
		t_power_bad;
		t_controls;
		wrap_up;
	end
	// well above the roughly 13k cycles the sequence needs
	initial begin
		repeat (60000) @(posedge ref_clk);
		failures++;
		wrap_up;
	end
endmodule : test_fault_status_latch_register
`default_nettype wire
